// File: hw/hbc_rst_delay.sv
`timescale 1ns/1ps
module hbc_rst_delay
  import hbc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Reset pin and sources
  input  wire logic rst_pin_in,
  input  wire logic por,
  input  wire logic wdog_rst,
  output logic      rst_pin_o,
  output logic      rst_pin_oe,
  // Released reset to core
  output logic      core_rst
);
  hbc_rst_state_t         state;
  logic [RST_CNT_W-1:0]   cnt;

  // Pull-down acts without the clock so power loss always resets
  assign rst_pin_o  = 1'b0;
  assign rst_pin_oe = por | wdog_rst; // R18

  // Short pin pulses still restart the full delay
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !rst_pin_in) begin
      state <= HBC_RST_HOLD;
      cnt   <= '0;
    end else begin
      case (state)
        HBC_RST_HOLD: begin
          state <= HBC_RST_COUNT;
          cnt   <= '0;
        end
        HBC_RST_COUNT: begin
          if (cnt == RST_CNT_LAST) begin // R19
            state <= HBC_RST_RUN;
          end else begin
            cnt <= cnt + 1'b1; // R19
          end
        end
        default: state <= HBC_RST_RUN;
      endcase
    end
  end

  assign core_rst = (state != HBC_RST_RUN);

  default clocking @(posedge clk_sys); endclocking

  release_delay_a: assert property ($fell(core_rst) |-> cnt == RST_CNT_LAST) // R19
    else $error("core reset released before full delay");
  hold_low_a: assert property (disable iff (sys_rst) !rst_pin_in |=> core_rst) // R19
    else $error("core reset not held while pin low");
  pulldown_a: assert property (por |-> rst_pin_oe && !rst_pin_o) // R18
    else $error("reset pull-down not driven on power-on reset");
  release_cov: cover property ($fell(core_rst));
endmodule

// File: hw/hbc_sync.sv
`timescale 1ns/1ps
module hbc_sync
  import hbc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  // Raw comparator levels
  input  wire logic [NFLAG-1:0] cmp_raw,
  // Synchronised levels
  hbc_cmp_if.src                sync
);
  logic [NFLAG-1:0] stage1;
  logic [NFLAG-1:0] stage2;

  // Analog comparators are asynchronous to the main clock
  genvar i;
  generate
    for (i = 0; i < NFLAG; i++) begin : g_sync
      always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
        end else begin
          stage1[i] <= cmp_raw[i]; // R20
          stage2[i] <= stage1[i]; // R20
        end
      end
    end
  endgenerate

  assign sync.lvl = stage2;
endmodule

// File: hw/hbc_top.sv
`timescale 1ns/1ps
// Contract
// R1: Control bits: enables, levels, irq enable; bit6 zero
// R2: Enable off: both switches off; level picks side
// R3: Control and status reset to all zeros
// R4: Edge polarity bit selects port edge direction
// R5: Multiplex bit routes bus I/O to lines
// R6: Diagnostic irq needs enable and option bit4
// R7: Status flags at bits 3..7; low bits zero
// R8: Short flag set by fault, cleared by software
// R9: Short flag forces both enables cleared
// R10: Software clears short flag, then re-enables
// R11: Overvoltage sets flag and switches bridge off
// R12: Undervoltage flag sticky, never switches bridge off
// R13: Temperature flags sticky, never switch bridge off
// R14: Any flag rising raises request zero; the code raises it only on a rise of the ORed flags
// R15: Request flop cleared at service entry
// R16: Software rechecks all flags before leaving service
// R17: Regulator standby in stop, normal otherwise
// R18: Power-on reset turns on pin pull-down
// R19: Release core reset 2048 cycles after pin high
// R20: Comparators pass two-stage synchroniser first
module hbc_top
  import hbc_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  // CPU data bus
  input  wire logic [7:0]    bus_addr,
  input  wire logic          bus_wr,
  input  wire logic          bus_rd,
  input  wire logic [DW-1:0] bus_wdata,
  output logic      [DW-1:0] bus_rdata,
  // Power stage comparators
  input  wire logic          cmp_short,
  input  wire logic          cmp_over_v,
  input  wire logic          cmp_under_v,
  input  wire logic          cmp_temp1,
  input  wire logic          cmp_temp2,
  // Interrupt line zero
  input  wire logic          ior_diag_gate,
  input  wire logic          isr_entry,
  output logic               irq0_req,
  // Half bridge switches
  output logic      [1:0]    high_side_switch,
  output logic      [1:0]    low_side_switch,
  // Port lines
  input  wire logic [3:0]    port_pin_in,
  output logic      [3:0]    port_edge_event,
  input  wire logic [1:0]    gpio_o,
  input  wire logic [1:0]    gpio_oe,
  output logic      [1:0]    gpio_i,
  input  wire logic          can_tx,
  output logic               can_rx,
  output logic      [1:0]    port_lines_zero_one_o,
  output logic      [1:0]    port_lines_zero_one_oe,
  // Regulator and reset
  input  wire logic          cpu_stop,
  output logic               regulator_standby,
  input  wire logic          por,
  input  wire logic          wdog_rst,
  input  wire logic          rst_pin_in,
  output logic               rst_pin_o,
  output logic               rst_pin_oe,
  output logic               core_rst
);
  logic [DW-1:0]    bridge_port_control;
  logic [NFLAG-1:0] flags;
  logic [NFLAG-1:0] next_flags;
  logic [NFLAG-1:0] flag_clr;
  logic             any_prev;
  logic             any_rise;
  logic             irq_gate;
  logic [3:0]       port_prev;
  logic             wr_ctrl;
  logic             wr_stat;
  logic [DW-1:0]    next_ctrl;

  hbc_cmp_if cmp_bus ();

  hbc_sync u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .cmp_raw ({cmp_temp2, cmp_temp1, cmp_under_v, cmp_over_v, cmp_short}),
    .sync    (cmp_bus.src)
  );

  hbc_rst_delay u_rst (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .rst_pin_in (rst_pin_in),
    .por        (por),
    .wdog_rst   (wdog_rst),
    .rst_pin_o  (rst_pin_o),
    .rst_pin_oe (rst_pin_oe),
    .core_rst   (core_rst)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    return a == reg_addr;
  endfunction

  assign wr_ctrl = bus_wr && hit(bus_addr, ADDR_CTRL);
  assign wr_stat = bus_wr && hit(bus_addr, ADDR_STAT);

  // Status flags: set wins over a clearing write in the same cycle
  assign flag_clr   = wr_stat ? ~bus_wdata[STAT_LSB +: NFLAG] : '0; // R8
  assign next_flags = (flags & ~flag_clr) | cmp_bus.lvl; // R8 R11 R12 R13

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags <= STAT_RESET[STAT_LSB +: NFLAG]; // R3
    end else begin
      flags <= next_flags; // R12 R13
    end
  end

  // Control register; short flag dominates any enable write
  always_comb begin
    next_ctrl = bridge_port_control;
    if (wr_ctrl) begin
      next_ctrl = bus_wdata;
    end
    next_ctrl[CTRL_UNUSED] = 1'b0; // R1
    if (next_flags[FLG_SC]) begin
      next_ctrl[CTRL_EN1] = 1'b0; // R9
      next_ctrl[CTRL_EN2] = 1'b0; // R9
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bridge_port_control <= CTRL_RESET; // R3
    end else begin
      bridge_port_control <= next_ctrl; // R1
    end
  end

  // Register reads
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_rdata <= RDATA_UNMAPPED;
    end else if (bus_rd) begin
      if (hit(bus_addr, ADDR_CTRL)) begin
        bus_rdata <= bridge_port_control; // R1
      end else if (hit(bus_addr, ADDR_STAT)) begin
        bus_rdata <= {flags, 3'h0}; // R7
      end else begin
        bus_rdata <= RDATA_UNMAPPED;
      end
    end
  end

  // Bridge switches; overvoltage turns off without touching enables
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      high_side_switch <= 2'h0;
      low_side_switch  <= 2'h0;
    end else begin
      for (int b = 0; b < 2; b++) begin
        high_side_switch[b] <= bridge_port_control[CTRL_EN1 + b] &&
                               bridge_port_control[CTRL_LVL1 + b] && !flags[FLG_OV]; // R2 R11
        low_side_switch[b]  <= bridge_port_control[CTRL_EN1 + b] &&
                               !bridge_port_control[CTRL_LVL1 + b] && !flags[FLG_OV]; // R2 R11
      end
    end
  end

  // One request per rise of the ORed flags; later flags are not stored
  assign any_rise = (|flags) && !any_prev; // R14 R15
  assign irq_gate = bridge_port_control[CTRL_DIAGIE] && ior_diag_gate; // R6

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      any_prev <= 1'b0;
      irq0_req <= 1'b0;
    end else begin
      any_prev <= |flags; // R14
      if (any_rise && irq_gate) begin
        irq0_req <= 1'b1; // R14 R6
      end else if (isr_entry) begin
        irq0_req <= 1'b0; // R15
      end
    end
  end

  // Port edge events; polarity chosen by control bit
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      port_prev       <= 4'h0;
      port_edge_event <= 4'h0;
    end else begin
      port_prev <= port_pin_in;
      if (bridge_port_control[CTRL_PEDGE]) begin
        port_edge_event <= port_pin_in & ~port_prev; // R4
      end else begin
        port_edge_event <= ~port_pin_in & port_prev; // R4
      end
    end
  end

  // Lines zero and one: line 0 receives, line 1 transmits in bus mode
  always_comb begin
    if (bridge_port_control[CTRL_BUSMUX]) begin
      port_lines_zero_one_o  = {can_tx, 1'b0}; // R5
      port_lines_zero_one_oe = 2'h2; // R5
      can_rx                 = port_pin_in[0]; // R5
      gpio_i                 = 2'h0;
    end else begin
      port_lines_zero_one_o  = gpio_o; // R5
      port_lines_zero_one_oe = gpio_oe; // R5
      can_rx                 = 1'b1;
      gpio_i                 = port_pin_in[1:0];
    end
  end

  // Regulator mode follows stop; reset returns it to normal
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      regulator_standby <= 1'b0; // R17
    end else begin
      regulator_standby <= cpu_stop; // R17
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  reset_zero_a: assert property (disable iff (1'b0) sys_rst |=> bridge_port_control == CTRL_RESET && flags == '0) // R3
    else $error("registers not zero after reset");
  short_blocks_en_a: assert property (flags[FLG_SC] |-> bridge_port_control[1:0] == 2'h0) // R9
    else $error("enable set while short flag set");
  bridge_off_a: assert property (!bridge_port_control[CTRL_EN1] |=> !high_side_switch[0] && !low_side_switch[0]) // R2
    else $error("bridge one driven while disabled");
  sink_mode_a: assert property (bridge_port_control[CTRL_EN2] && !bridge_port_control[CTRL_LVL2] && !flags[FLG_OV]
                                |=> low_side_switch[1] && !high_side_switch[1]) // R2
    else $error("bridge two not sinking");
  ov_off_a: assert property (flags[FLG_OV] |=> high_side_switch == 2'h0 && low_side_switch == 2'h0) // R11
    else $error("bridge on during overvoltage");
  flag_sticky_a: assert property (cmp_bus.lvl[FLG_UNV] ##1 !flag_clr[FLG_UNV] |-> flags[FLG_UNV] [*2]) // R12
    else $error("undervoltage flag not held");
  sc_clear_a: assert property (flags[FLG_SC] && !wr_stat |=> flags[FLG_SC]) // R8
    else $error("short flag cleared without software");
  irq_gate_a: assert property ($rose(irq0_req) |-> $past(irq_gate) && $past(any_rise)) // R6 R14
    else $error("request without enabled rising flag");
  isr_clear_a: assert property (isr_entry && !(any_rise && irq_gate) |=> !irq0_req) // R15
    else $error("request survived service entry");
  bit6_zero_a: assert property (bus_rd && bus_addr == ADDR_CTRL |=> bus_rdata[CTRL_UNUSED] == 1'b0) // R1
    else $error("control bit6 read as one");
  stat_low_a: assert property (bus_rd && bus_addr == ADDR_STAT |=> bus_rdata[2:0] == 3'h0) // R7
    else $error("status low bits not zero");

  // A clearing write only wins once the comparator has let go
  unv_hold_a: assert property (flags[FLG_UNV] && !flag_clr[FLG_UNV] |=> flags[FLG_UNV]) // R12
    else $error("undervoltage flag lost without software");
  temp_hold_a: assert property (flags[FLG_OT1] && !flag_clr[FLG_OT1] |=> flags[FLG_OT1]) // R13
    else $error("temperature flag lost without software");
  sc_set_a: assert property (cmp_bus.lvl[FLG_SC] |=> flags[FLG_SC]) // R8
    else $error("short flag not set by comparator");
  ov_set_a: assert property (cmp_bus.lvl[FLG_OV] |=> flags[FLG_OV]) // R11
    else $error("overvoltage flag not set by comparator");
  temp1_set_a: assert property (cmp_bus.lvl[FLG_OT1] |=> flags[FLG_OT1]) // R13
    else $error("first temperature flag not set");
  temp2_set_a: assert property (cmp_bus.lvl[FLG_OT2] |=> flags[FLG_OT2]) // R13
    else $error("second temperature flag not set");
  source_mode_a: assert property (bridge_port_control[CTRL_EN1] && bridge_port_control[CTRL_LVL1] // R2 R11
                                  && !flags[FLG_OV] |=> high_side_switch[0] && !low_side_switch[0])
    else $error("bridge one not sourcing");
  ctrl_write_a: assert property (wr_ctrl && !next_flags[FLG_SC] |=> // R1 R10
                                 bridge_port_control == {$past(bus_wdata[7]), 1'b0, $past(bus_wdata[5:0])})
    else $error("control write did not land");
  rdata_hold_a: assert property (!bus_rd |=> $stable(bus_rdata)) // R7
    else $error("read data changed without a read");
  edge_only_a: assert property (port_edge_event[0] |-> $past(port_pin_in[0]) != $past(port_pin_in[0], 2)) // R4
    else $error("port event without a pin edge");
  mux_bus_a: assert property (bridge_port_control[CTRL_BUSMUX] |-> can_rx == port_pin_in[0] && gpio_i == 2'h0) // R5
    else $error("bus mode lines not routed");
  mux_io_a: assert property (!bridge_port_control[CTRL_BUSMUX] |-> can_rx && gpio_i == port_pin_in[1:0] // R5
                             && port_lines_zero_one_o == gpio_o && port_lines_zero_one_oe == gpio_oe)
    else $error("port lines not plain in port mode");
  standby_a: assert property (cpu_stop |=> regulator_standby) // R17
    else $error("regulator not in standby during stop");
  normal_a: assert property (!cpu_stop |=> !regulator_standby) // R17
    else $error("regulator standby outside stop");
  irq_set_a: assert property (any_rise && irq_gate |=> irq0_req) // R14
    else $error("enabled flag rise gave no request");
  irq_off_a: assert property (!(any_rise && irq_gate) && !irq0_req |=> !irq0_req) // R15
    else $error("request raised without a fresh rise");
  irq_hold_a: assert property (irq0_req && !isr_entry |=> irq0_req) // R15
    else $error("request dropped before service entry");

  short_cov: cover property (flags[FLG_SC] ##1 wr_stat ##[1:20] wr_ctrl);
  irq_cov: cover property ($rose(irq0_req) ##[1:10] isr_entry);
  standby_cov: cover property ($rose(regulator_standby) ##[1:20] $fell(regulator_standby));
  edge_cov: cover property ($rose(port_edge_event[0]));
endmodule

// File: inc/hbc_cmp_if.sv
`timescale 1ns/1ps
interface hbc_cmp_if;
  import hbc_pkg::*;
  logic [NFLAG-1:0] lvl;
  modport src (output lvl);
  modport dst (input lvl);
endinterface

// File: inc/hbc_pkg.sv
package hbc_pkg;
  // Register map and widths
  localparam int        DW             = 8;
  localparam logic [7:0] ADDR_CTRL     = 8'hE2;
  localparam logic [7:0] ADDR_STAT     = 8'hE3;
  localparam logic [7:0] CTRL_RESET    = 8'h00;
  localparam logic [7:0] STAT_RESET    = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // Control register fields
  localparam int CTRL_EN1    = 0;
  localparam int CTRL_EN2    = 1;
  localparam int CTRL_LVL1   = 2;
  localparam int CTRL_LVL2   = 3;
  localparam int CTRL_PEDGE  = 4;
  localparam int CTRL_BUSMUX = 5;
  localparam int CTRL_UNUSED = 6;
  localparam int CTRL_DIAGIE = 7;

  // Status register fields; comparator vector uses the same order
  localparam int STAT_LSB    = 3;
  localparam int NFLAG       = 5;
  localparam int FLG_SC      = 0;
  localparam int FLG_OV      = 1;
  localparam int FLG_UNV     = 2;
  localparam int FLG_OT1     = 3;
  localparam int FLG_OT2     = 4;

  // Reset pin release delay in main clock cycles
  localparam int            RST_DELAY_CYC = 2048;
  localparam int            RST_CNT_W     = 12;
  localparam logic [11:0]   RST_CNT_LAST  = 12'(RST_DELAY_CYC - 1);

  typedef enum logic [1:0] {HBC_RST_HOLD, HBC_RST_COUNT, HBC_RST_RUN} hbc_rst_state_t;
endpackage

// File: sim/hbc_sense_model.sv
`timescale 1ns/1ps
module hbc_sense_model (
  // Fault requests from the bench
  input  wire logic [4:0] fault_req,
  // Comparator levels toward the block
  output logic      [4:0] cmp_lvl
);
  initial cmp_lvl = 5'h00;
  // Comparators settle off any clock edge, so the synchroniser sees real skew
  always @(fault_req) cmp_lvl <= #3 fault_req;
endmodule

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import hbc_pkg::*;
  logic          clk_sys = 1'h0;
  logic          sys_rst = 1'h1;
  logic [7:0]    bus_addr = 8'h00;
  logic [DW-1:0] bus_wdata = 8'h00;
  logic          bus_wr = 1'h0, bus_rd = 1'h0, ior_diag_gate = 1'h0, isr_entry = 1'h0;
  logic          can_tx = 1'h0, cpu_stop = 1'h0, por = 1'h0, wdog_rst = 1'h0, rst_pin_in = 1'h1;
  logic [3:0]    port_pin_in = 4'h0;
  logic [1:0]    gpio_o = 2'h0, gpio_oe = 2'h0;
  logic [4:0]    fault_req = 5'h00, cmp;
  logic [DW-1:0] bus_rdata;
  logic          irq0_req, can_rx, regulator_standby, rst_pin_o, rst_pin_oe, core_rst;
  logic [1:0]    hs, ls, gpio_i, pl_o, pl_oe;
  logic [3:0]    port_edge_event;
  int            fail_count = 0;
  int            tests_run = 0;

  always #4 clk_sys = ~clk_sys;

  hbc_sense_model sense (.fault_req(fault_req), .cmp_lvl(cmp));

  hbc_top dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .cmp_short(cmp[FLG_SC]), .cmp_over_v(cmp[FLG_OV]),
    .cmp_under_v(cmp[FLG_UNV]), .cmp_temp1(cmp[FLG_OT1]), .cmp_temp2(cmp[FLG_OT2]),
    .ior_diag_gate(ior_diag_gate), .isr_entry(isr_entry), .irq0_req(irq0_req),
    .high_side_switch(hs), .low_side_switch(ls), .port_pin_in(port_pin_in),
    .port_edge_event(port_edge_event), .gpio_o(gpio_o), .gpio_oe(gpio_oe), .gpio_i(gpio_i),
    .can_tx(can_tx), .can_rx(can_rx), .port_lines_zero_one_o(pl_o), .port_lines_zero_one_oe(pl_oe),
    .cpu_stop(cpu_stop), .regulator_standby(regulator_standby), .por(por), .wdog_rst(wdog_rst),
    .rst_pin_in(rst_pin_in), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .core_rst(core_rst)
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // All bus tasks start and end at a falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'h1;
    cyc(1);
    bus_wr = 1'h0;
    cyc(1);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus_addr = a;
    bus_rd = 1'h1;
    cyc(1);
    bus_rd = 1'h0;
    chk8(bus_rdata, exp);
    cyc(1);
  endtask

  // Six edges cover two sync stages, the flag, the request and the switches
  task automatic flt(input logic [4:0] f);
    fault_req = f;
    cyc(6);
  endtask

  task automatic isr();
    isr_entry = 1'h1;
    cyc(1);
    isr_entry = 1'h0;
    cyc(1);
  endtask

  task automatic t_reset();
    rdc(ADDR_CTRL, CTRL_RESET);
    rdc(ADDR_STAT, STAT_RESET);
    rdc(8'hE4, RDATA_UNMAPPED);
    chk8({4'h0, hs, ls}, 8'h00);
    chk1(irq0_req, 1'h0);
    chk1(regulator_standby, 1'h0);
    chk1(core_rst, 1'h1);
  endtask

  task automatic t_bridge();
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_CTRL, 8'h40 | 8'(i));
      wr(8'hE4, 8'hFF);
      rdc(ADDR_CTRL, 8'(i));
      chk8({6'h00, i[1] & i[3], i[0] & i[2]}, {6'h00, hs});
      chk8({6'h00, i[1] & ~i[3], i[0] & ~i[2]}, {6'h00, ls});
    end
  endtask

  task automatic t_short();
    ior_diag_gate = 1'h1;
    wr(ADDR_CTRL, 8'h83);
    flt(5'h01);
    chk8({4'h0, hs, ls}, 8'h00);
    rdc(ADDR_CTRL, 8'h80);
    rdc(ADDR_STAT, 8'h08);
    chk1(irq0_req, 1'h1);
    isr();
    chk1(irq0_req, 1'h0);
    flt(5'h09);
    chk1(irq0_req, 1'h0);
    wr(ADDR_CTRL, 8'h83);
    rdc(ADDR_CTRL, 8'h80);
    flt(5'h00);
    rdc(ADDR_STAT, 8'h48);
    wr(ADDR_STAT, 8'hF7);
    rdc(ADDR_STAT, 8'h40);
    chk1(irq0_req, 1'h0);
    wr(ADDR_STAT, 8'h00);
    rdc(ADDR_STAT, 8'h00);
    wr(ADDR_CTRL, 8'h83);
    cyc(1);
    chk8({6'h00, ls}, 8'h03);
  endtask

  task automatic t_volt_temp();
    ior_diag_gate = 1'h0;
    wr(ADDR_CTRL, 8'h8F);
    flt(5'h02);
    chk8({6'h00, hs}, 8'h00);
    wr(ADDR_STAT, 8'h00);
    rdc(ADDR_STAT, 8'h10);
    chk1(irq0_req, 1'h0);
    flt(5'h1C);
    wr(ADDR_STAT, 8'h00);
    flt(5'h1C);
    rdc(ADDR_STAT, 8'hE0);
    flt(5'h00);
    wr(ADDR_STAT, 8'h00);
    cyc(1);
    chk8({6'h00, hs}, 8'h03);
    ior_diag_gate = 1'h1;
    flt(5'h10);
    chk1(irq0_req, 1'h1);
    chk8({6'h00, hs}, 8'h03);
    rdc(ADDR_STAT, 8'h80);
    isr();
    flt(5'h00);
    wr(ADDR_STAT, 8'h00);
    rdc(ADDR_STAT, 8'h00);
  endtask

  task automatic pin_go(input logic [3:0] v, input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    port_pin_in = v;
    repeat (4) begin
      cyc(1);
      seen = seen | port_edge_event;
    end
    chk8({4'h0, seen}, {4'h0, exp});
  endtask

  task automatic t_edge(input logic pol);
    wr(ADDR_CTRL, {3'h0, pol, 4'h0});
    cyc(2);
    pin_go(4'hF, pol ? 4'hF : 4'h0);
    pin_go(4'h0, pol ? 4'h0 : 4'hF);
  endtask

  task automatic t_mux();
    gpio_o = 2'h2;
    gpio_oe = 2'h3;
    can_tx = 1'h1;
    port_pin_in = 4'h2;
    wr(ADDR_CTRL, 8'h00);
    chk8({4'h0, pl_o, pl_oe}, 8'h0B);
    chk8({6'h00, gpio_i}, 8'h02);
    chk1(can_rx, 1'h1);
    wr(ADDR_CTRL, 8'h20);
    chk8({5'h00, pl_o[1], pl_oe}, 8'h06);
    chk8({6'h00, gpio_i}, 8'h00);
    chk1(can_rx, 1'h0);
    port_pin_in = 4'h1;
    can_tx = 1'h0;
    cyc(1);
    chk1(pl_o[1], 1'h0);
    chk1(can_rx, 1'h1);
  endtask

  task automatic t_power();
    int n;
    cpu_stop = 1'h1;
    cyc(2);
    chk1(regulator_standby, 1'h1);
    cpu_stop = 1'h0;
    cyc(2);
    chk1(regulator_standby, 1'h0);
    por = 1'h1;
    cyc(1);
    chk8({6'h00, rst_pin_o, rst_pin_oe}, 8'h01);
    por = 1'h0;
    cyc(1);
    chk1(rst_pin_oe, 1'h0);
    wdog_rst = 1'h1;
    cyc(1);
    chk1(rst_pin_oe, 1'h1);
    wdog_rst = 1'h0;
    rst_pin_in = 1'h0;
    cyc(3);
    chk1(core_rst, 1'h1);
    rst_pin_in = 1'h1;
    n = 0;
    while (core_rst !== 1'h0 && n < 2200) begin
      cyc(1);
      n++;
    end
    chk1(n >= 2048 && n <= 2051, 1'h1);
  endtask

  // Cuts a hang short well beyond the longest sequence
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end

  initial begin
    cyc(3);
    sys_rst = 1'h0;
    cyc(1);
    t_reset();
    t_bridge();
    t_short();
    t_volt_temp();
    t_edge(1'h1);
    t_edge(1'h0);
    t_mux();
    t_power();
    finish_test();
  end
endmodule
